// ### hw/adf_filter_core.sv
// Eight-channel decimation, DC-block and phase-offset engine behind an APB slave
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module adf_filter_core
  import adf_pkg::*;
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Modulator bitstreams, one per channel
  input  wire logic [ADF_NCH-1:0] mod_bit,
  // New-result flags
  output logic      [ADF_NCH-1:0] data_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Register region of an address
  function automatic adf_reg_type adf_decode(input logic [7:0] addr);
    adf_reg_type r;
    r = ADF_REG_NONE;
    if (addr[1:0] == 2'b00) begin
      if (addr == ADF_OFS_CTRL) r = ADF_REG_CTRL;
      else if (addr == ADF_OFS_THR_LOW) r = ADF_REG_THR;
      else if (addr == ADF_OFS_STATUS) r = ADF_REG_STATUS;
      else if (addr[7:5] == ADF_PAGE_CFG) r = ADF_REG_CFG;
      else if (addr[7:5] == ADF_PAGE_DATA) r = ADF_REG_DATA;
    end
    return r;
  endfunction

  // Saturate a wide value to the 24-bit result range
  function automatic logic [23:0] adf_sat24(input logic signed [33:0] x);
    logic [23:0] r;
    if (x > 34'sh00007fffff) r = 24'h7fffff;
    else if (x < -34'sh0000800000) r = 24'h800000;
    else r = x[23:0];
    return r;
  endfunction

  // Clip a signed offset to +-half the window; mask is window length minus one
  function automatic logic [9:0] adf_clip(input logic [9:0] ph, input logic [9:0] mask);
    logic signed [9:0] hi;
    logic signed [9:0] lo;
    logic [9:0]        r;
    hi = $signed({1'b0, mask[9:1]});
    lo = ~hi;
    r  = ph;
    if ($signed(ph) > hi) r = hi;
    else if ($signed(ph) < lo) r = lo;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  adf_bus_type             bus_state;
  adf_reg_type             bus_reg;
  logic [2:0]              osr_code;
  logic [3:0]              highpass_cutoff_code;
  logic [9:0]              chan_phase_offset [ADF_NCH];
  adf_mux_type             chan_input_select [ADF_NCH];
  logic [ADF_NCH-1:0]      chan_highpass_disable;
  logic                    bus_wr;
  logic [ADF_CH_AW-1:0]    bus_idx;
  logic [ADF_DATA_W-1:0]   mem_rd_data;
  logic [ADF_NCH-1:0]      fast_vec;

  assign bus_reg = adf_decode(paddr);
  assign bus_idx = paddr[4:2];
  // A write lands only on the edge where pready is seen high
  assign bus_wr  = (bus_state == ADF_BUS_DONE) && psel && penable && pwrite;

  // Transfer sequencer: one wait state covers the memory read latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state <= ADF_BUS_IDLE;
    end else begin
      case (bus_state)
        ADF_BUS_IDLE: if (psel && !penable) bus_state <= ADF_BUS_READ;
        ADF_BUS_READ: if (psel && penable) bus_state <= ADF_BUS_DONE;
        ADF_BUS_DONE: bus_state <= ADF_BUS_IDLE;
        default:      bus_state <= ADF_BUS_IDLE;
      endcase
    end
  end

  // Answer flops: data, ready and error settle together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (bus_state == ADF_BUS_READ && psel && penable) begin
      pready  <= 1'b1;
      pslverr <= (bus_reg == ADF_REG_NONE);
      prdata  <= '0;
      if (!pwrite) begin
        case (bus_reg)
          ADF_REG_CTRL:   prdata[ADF_CTRL_OSR_LSB +: 3] <= osr_code;
          ADF_REG_THR:    prdata[ADF_THR_CUTOFF_LSB +: 4] <= highpass_cutoff_code;
          ADF_REG_STATUS: begin
            prdata[ADF_STAT_READY_LSB +: ADF_NCH] <= data_ready;
            prdata[ADF_STAT_FAST_LSB +: ADF_NCH]  <= fast_vec;
          end
          ADF_REG_CFG: begin
            prdata[ADF_CFG_PHASE_LSB +: 10] <= chan_phase_offset[bus_idx];
            prdata[ADF_CFG_MUX_LSB +: 2]    <= chan_input_select[bus_idx];
            prdata[ADF_CFG_HPDIS_BIT]       <= chan_highpass_disable[bus_idx];
          end
          ADF_REG_DATA:   prdata[ADF_DATA_W-1:0] <= mem_rd_data;
          default:        prdata <= '0;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Global settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osr_code             <= ADF_RST_OSR;
      highpass_cutoff_code <= ADF_RST_CUTOFF;
    end else if (bus_wr) begin
      if (bus_reg == ADF_REG_CTRL) osr_code <= pwdata[ADF_CTRL_OSR_LSB +: 3];
      if (bus_reg == ADF_REG_THR) highpass_cutoff_code <= pwdata[ADF_THR_CUTOFF_LSB +: 4];
    end
  end

  // Per-channel configuration words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ADF_NCH; i++) begin
        chan_phase_offset[i] <= ADF_RST_PHASE;
        chan_input_select[i] <= ADF_MUX_INPUT;
      end
      chan_highpass_disable <= {ADF_NCH{ADF_RST_HPDIS}};
    end else if (bus_wr && bus_reg == ADF_REG_CFG) begin
      chan_phase_offset[bus_idx]     <= pwdata[ADF_CFG_PHASE_LSB +: 10];
      chan_input_select[bus_idx]     <= adf_mux_type'(pwdata[ADF_CFG_MUX_LSB +: 2]);
      chan_highpass_disable[bus_idx] <= pwdata[ADF_CFG_HPDIS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator timebase and shared test streams

  logic [3:0] div_cnt;
  logic       mod_tick;
  logic [9:0] mod_cnt;
  logic [5:0] test_pos_acc;
  logic [5:0] test_neg_acc;
  logic       test_pos_bit;
  logic       test_neg_bit;

  // Modulator sample strobe derived from the one input clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt  <= '0;
      mod_tick <= 1'b0;
    end else begin
      mod_tick <= (div_cnt == 4'(ADF_MOD_DIV - 1));
      div_cnt  <= (div_cnt == 4'(ADF_MOD_DIV - 1)) ? 4'h0 : div_cnt + 4'h1;
    end
  end

  // Free-running sample index; all windows are cut from it, so they stay aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mod_cnt <= '0;
    else if (mod_tick) mod_cnt <= mod_cnt + 10'h001;
  end

  // First-order digital modulators give ones densities of 17/30 and 13/30
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_pos_acc <= '0;
      test_neg_acc <= '0;
      test_pos_bit <= 1'b0;
      test_neg_bit <= 1'b0;
    end else if (mod_tick) begin
      test_pos_bit <= (test_pos_acc + ADF_TEST_POS_INC) >= ADF_TEST_MOD;
      test_neg_bit <= (test_neg_acc + ADF_TEST_NEG_INC) >= ADF_TEST_MOD;
      test_pos_acc <= ((test_pos_acc + ADF_TEST_POS_INC) >= ADF_TEST_MOD) ?
                      test_pos_acc + ADF_TEST_POS_INC - ADF_TEST_MOD :
                      test_pos_acc + ADF_TEST_POS_INC;
      test_neg_acc <= ((test_neg_acc + ADF_TEST_NEG_INC) >= ADF_TEST_MOD) ?
                      test_neg_acc + ADF_TEST_NEG_INC - ADF_TEST_MOD :
                      test_neg_acc + ADF_TEST_NEG_INC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ratio decoding

  logic [1:0] s3_code;
  logic [9:0] win_mask;
  logic [2:0] post_shift;
  logic [3:0] post_last;
  logic       hp_global;

  always_comb begin
    s3_code    = (osr_code > ADF_SINC3_MAX_CODE) ? 2'h3 : osr_code[1:0];
    win_mask   = {s3_code == 2'h3, s3_code >= 2'h2, s3_code >= 2'h1, ADF_BASE_MASK};
    post_shift = (osr_code > ADF_SINC3_MAX_CODE) ? osr_code - ADF_SINC3_MAX_CODE : 3'h0;
    post_last  = 4'((5'h01 << post_shift) - 5'h01);
    hp_global  = (highpass_cutoff_code != 4'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel pipelines

  logic [ADF_NCH-1:0]            out_vec;
  logic [ADF_NCH*ADF_DATA_W-1:0] hold_flat;

  for (genvar ch = 0; ch < ADF_NCH; ch++) begin : g_ch
    logic signed [31:0] i1, i2, i3, d1, d2, d3, c1, c2, c3;
    logic signed [11:0] fast_acc, fast_sum;
    logic signed [33:0] s3_scaled, fast_scaled;
    logic signed [27:0] post_acc, post_sum;
    logic signed [39:0] base;
    logic signed [41:0] resid;
    logic [9:0]         phase_clip;
    logic [9:0]         win_pos;
    logic               win_end, evt, s3_v, fin_v, sbit, bypass;
    logic [23:0]        s3_x, fin_x, out_x;
    logic [3:0]         post_cnt;
    logic [1:0]         conv_cnt;

    // Source selection and window placement
    always_comb begin
      case (chan_input_select[ch])
        ADF_MUX_INPUT:    sbit = mod_bit[ch];
        ADF_MUX_SHORT:    sbit = mod_cnt[0];
        ADF_MUX_TEST_POS: sbit = test_pos_bit;
        ADF_MUX_TEST_NEG: sbit = test_neg_bit;
        default:          sbit = mod_bit[ch];
      endcase
      phase_clip = adf_clip(chan_phase_offset[ch], win_mask);
      win_pos    = mod_cnt - phase_clip;
      win_end    = (win_pos & win_mask) == win_mask;
    end

    // Integrators run on every modulator sample
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        i1 <= '0;
        i2 <= '0;
        i3 <= '0;
      end else if (mod_tick) begin
        i1 <= i1 + (sbit ? 32'sd1 : -32'sd1);
        i2 <= i2 + i1;
        i3 <= i3 + i2;
      end
    end

    // Fast-settling boxcar over the same window
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fast_acc <= '0;
        fast_sum <= '0;
        evt      <= 1'b0;
      end else begin
        evt <= mod_tick && win_end;
        if (mod_tick) begin
          fast_acc <= win_end ? 12'sd0 : fast_acc + (sbit ? 12'sd1 : -12'sd1);
          if (win_end) fast_sum <= fast_acc + (sbit ? 12'sd1 : -12'sd1);
        end
      end
    end

    // Combs and normalisation to 24 bits
    always_comb begin
      c1          = i3 - d1;
      c2          = c1 - d2;
      c3          = c2 - d3;
      s3_scaled   = ($signed({{2{c3[31]}}, c3}) <<< 2) >>> (4'(s3_code) * 4'h3);
      fast_scaled = $signed({{22{fast_sum[11]}}, fast_sum}) <<< (5'h10 - 5'(s3_code));
    end

    // Decimated stage, fast path for the first two conversions only
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        d1   <= '0;
        d2   <= '0;
        d3   <= '0;
        s3_v <= 1'b0;
        s3_x <= '0;
      end else begin
        s3_v <= evt;
        if (evt) begin
          d1   <= i3;
          d2   <= c1;
          d3   <= c2;
          s3_x <= adf_sat24((conv_cnt < ADF_FAST_CONVS) ? fast_scaled : s3_scaled);
        end
      end
    end

    // Sinc1 post-decimator above ratio 1024; a lowered ratio ends the sum at once
    assign post_sum = post_acc + 28'($signed(s3_x));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        post_acc <= '0;
        post_cnt <= '0;
        fin_v    <= 1'b0;
        fin_x    <= '0;
      end else begin
        fin_v <= 1'b0;
        if (s3_v && post_cnt >= post_last) begin
          fin_v    <= 1'b1;
          fin_x    <= 24'(post_sum >>> post_shift);
          post_acc <= '0;
          post_cnt <= '0;
        end else if (s3_v) begin
          post_acc <= post_sum;
          post_cnt <= post_cnt + 4'h1;
        end
      end
    end

    // DC-block, one update per output sample
    assign bypass = !hp_global || chan_highpass_disable[ch];
    assign resid  = $signed({{2{fin_x[23]}}, fin_x, 16'h0000}) - 42'(base);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        base  <= '0;
        out_x <= '0;
      end else if (fin_v) begin
        if (bypass) begin
          base  <= '0;
          out_x <= fin_x;
        end else begin
          // Shift of code+1 gives coefficient 2^-(code+1); settling doubles per step
          base  <= base + 40'(resid >>> (5'(highpass_cutoff_code) + 5'h01));
          out_x <= adf_sat24(34'(resid >>> ADF_HP_FRAC));
        end
      end
    end

    // Conversion count gates the fast path; saturates so it never returns
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) conv_cnt <= '0;
      else if (fin_v && conv_cnt < ADF_FAST_CONVS) conv_cnt <= conv_cnt + 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) out_vec[ch] <= 1'b0;
      else out_vec[ch] <= fin_v;
    end

    assign fast_vec[ch]                          = (conv_cnt < ADF_FAST_CONVS);
    assign hold_flat[ch*ADF_DATA_W +: ADF_DATA_W] = out_x;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result writer: aligned windows finish together, so results queue here

  logic [ADF_NCH-1:0]   pend;
  logic [ADF_NCH-1:0]   wr_clr;
  logic [ADF_CH_AW-1:0] wr_sel;
  logic                 wr_any;

  // Lowest pending channel first
  always_comb begin
    wr_sel = '0;
    wr_any = 1'b0;
    for (int i = ADF_NCH - 1; i >= 0; i--) begin
      if (pend[i]) begin
        wr_sel = ADF_CH_AW'(i);
        wr_any = 1'b1;
      end
    end
    wr_clr = wr_any ? (ADF_NCH'(1) << wr_sel) : '0;
  end

  // A new result in the clearing cycle keeps its pending bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend <= '0;
    else pend <= (pend & ~wr_clr) | out_vec;
  end

  // Ready flags: set by a stored result, cleared by writing ones; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ready <= '0;
    end else if (bus_wr && bus_reg == ADF_REG_STATUS) begin
      data_ready <= (data_ready & ~pwdata[ADF_STAT_READY_LSB +: ADF_NCH]) | wr_clr;
    end else begin
      data_ready <= data_ready | wr_clr;
    end
  end

  adf_result_mem #(
    .WIDTH (ADF_DATA_W),
    .DEPTH (ADF_NCH),
    .AW    (ADF_CH_AW)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_any),
    .wr_addr (wr_sel),
    .wr_data (hold_flat[32'(wr_sel)*ADF_DATA_W +: ADF_DATA_W]),
    .rd_addr (bus_idx),
    .rd_data (mem_rd_data)
  );

endmodule

`default_nettype wire

// ### hw/adf_pkg.sv
// Shared constants and types for the eight-channel ADC filter engine
package adf_pkg;

  localparam int ADF_NCH    = 8;
  localparam int ADF_DATA_W = 24;
  localparam int ADF_CH_AW  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets and pages
  localparam logic [7:0] ADF_OFS_CTRL    = 8'h00;
  localparam logic [7:0] ADF_OFS_THR_LOW = 8'h04;
  localparam logic [7:0] ADF_OFS_STATUS  = 8'h08;
  localparam logic [2:0] ADF_PAGE_CFG    = 3'h1;  // 0x20..0x3c, one word per channel
  localparam logic [2:0] ADF_PAGE_DATA   = 3'h2;  // 0x40..0x5c, one word per channel

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ADF_CTRL_OSR_LSB   = 0;
  localparam int ADF_THR_CUTOFF_LSB = 0;
  localparam int ADF_CFG_PHASE_LSB  = 0;
  localparam int ADF_CFG_MUX_LSB    = 12;
  localparam int ADF_CFG_HPDIS_BIT  = 16;
  localparam int ADF_STAT_READY_LSB = 0;
  localparam int ADF_STAT_FAST_LSB  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0] ADF_RST_OSR    = 3'h3;
  localparam logic [3:0] ADF_RST_CUTOFF = 4'h0;
  localparam logic [9:0] ADF_RST_PHASE  = 10'h000;
  localparam logic       ADF_RST_HPDIS  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing and filter constants
  localparam int         ADF_PCLK_HZ        = 20000000;
  localparam int         ADF_MOD_HZ         = 10000000;
  localparam int         ADF_MOD_DIV        = ADF_PCLK_HZ / ADF_MOD_HZ;
  localparam logic [1:0] ADF_FAST_CONVS     = 2'h2;
  localparam logic [2:0] ADF_SINC3_MAX_CODE = 3'h3;    // sinc3 ratio caps at 1024
  localparam logic [6:0] ADF_BASE_MASK      = 7'h7f;   // smallest window, 128, minus one
  localparam int         ADF_HP_FRAC        = 16;

  // Test stream density 17/30 ones gives 2/15 of full scale
  localparam logic [5:0] ADF_TEST_POS_INC = 6'h11;
  localparam logic [5:0] ADF_TEST_NEG_INC = 6'h0d;
  localparam logic [5:0] ADF_TEST_MOD     = 6'h1e;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    ADF_MUX_INPUT    = 2'b00,
    ADF_MUX_SHORT    = 2'b01,
    ADF_MUX_TEST_POS = 2'b10,
    ADF_MUX_TEST_NEG = 2'b11
  } adf_mux_type;

  typedef enum logic [1:0] {
    ADF_BUS_IDLE = 2'b00,
    ADF_BUS_READ = 2'b01,
    ADF_BUS_DONE = 2'b10
  } adf_bus_type;

  typedef enum logic [2:0] {
    ADF_REG_CTRL   = 3'b000,
    ADF_REG_THR    = 3'b001,
    ADF_REG_STATUS = 3'b010,
    ADF_REG_CFG    = 3'b011,
    ADF_REG_DATA   = 3'b100,
    ADF_REG_NONE   = 3'b111
  } adf_reg_type;

endpackage

// ### hw/adf_result_mem.sv
// Small result memory with registered read data
`timescale 1ns/10ps
`default_nettype none

module adf_result_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Cleared at reset so reads never return unknown data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data always one cycle after the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// ### testbench/adf_filter_monitor.sv
// Port checker for the filter engine, bound into every instance
`timescale 1ns/10ps
`default_nettype none
module adf_filter_monitor
  import adf_pkg::*;
(
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // APB slave side
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Result flags
  input wire logic [ADF_NCH-1:0] data_ready
);
  // Single domain, so one default clock and reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_ok;
  assign rd_ok = pready && !pwrite && !pslverr;
  //////////////////////////////////////////////////////////////////////////////
  wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  refuse_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused transfer returned data");
  cutoff_width_a: assert property (rd_ok && paddr == ADF_OFS_THR_LOW |->
    prdata[31:4] == 28'h0)
    else $error("cutoff register reserved bits set");
  cfg_fields_a: assert property (rd_ok && paddr[7:5] == ADF_PAGE_CFG |->
    prdata[31:17] == 15'h0 && prdata[15:14] == 2'h0 && prdata[11:10] == 2'h0)
    else $error("config word reserved bits set");
  data_width_a: assert property (rd_ok && paddr[7:5] == ADF_PAGE_DATA |->
    prdata[31:24] == 8'h0)
    else $error("result wider than 24 bits");
  flag_clear_a: assert property (|($past(data_ready) & ~data_ready) |->
    $past(pready && pwrite && paddr == ADF_OFS_STATUS))
    else $error("result flag dropped without a status write");
endmodule
bind adf_filter_core adf_filter_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .data_ready(data_ready)
);
`default_nettype wire

// ### testbench/adf_mod_source.sv
// Modulator stand-in: each channel streams constant ones or constant zeros
`timescale 1ns/10ps
`default_nettype none
module adf_mod_source
  import adf_pkg::*;
(
  // Clock
  input  wire logic               pclk,
  // Channels whose stream is all ones; the rest stream zeros
  input  wire logic [ADF_NCH-1:0] ones_mask,
  // Bitstreams toward the engine
  output logic      [ADF_NCH-1:0] mod_bit
);
  // Launched after the edge so the modulator strobe never races it
  always_ff @(posedge pclk) begin
    mod_bit <= ones_mask;
  end
endmodule
`default_nettype wire

// ### testbench/tb_adc_filter_dcblock_phase_cal.sv
// Self-checking bench for the filter engine through APB and result flags
`timescale 1ns/10ps
`default_nettype none
module tb_adc_filter_dcblock_phase_cal
  import adf_pkg::*;
;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [7:0]         ones_mask = 8'h0f;
  logic [31:0]        prdata, q;
  logic               pready, pslverr, e;
  logic [ADF_NCH-1:0] mod_bit, data_ready, prev_rdy;
  int                 mismatches = 0, total_checks = 0, cyc = 0, t0;
  int                 rise_t[ADF_NCH];

  // 20 MHz clock
  initial begin
    forever #25 pclk = ~pclk;
  end
  adf_mod_source i_src (.pclk(pclk), .ones_mask(ones_mask), .mod_bit(mod_bit));
  adf_filter_core i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mod_bit(mod_bit), .data_ready(data_ready)
  );
  // Cycle stamp of each flag's latest rise
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    prev_rdy <= data_ready;
    for (int i = 0; i < ADF_NCH; i++)
      if (data_ready[i] && !prev_rdy[i]) rise_t[i] <= cyc;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Four-state value in, so an unknown result fails the check
  function automatic logic near(logic signed [31:0] x, int c, int t);
    return x >= c - t && x <= c + t;
  endfunction
  // Circular distance within one 256-cycle window, so a missed clear cannot skew it
  function automatic int cd(int a, int b, int c);
    return ((a - b - c) % 256 + 384) % 256 - 128;
  endfunction
  function automatic logic [7:0] pg(logic [2:0] p, int c);
    return {p, 3'(c), 2'b00};
  endfunction
  // One APB transfer; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    if (n >= 50) complete_run();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next transfer never drives psel twice in one step
    @(posedge pclk);
  endtask
  // Clear the flags, then wait for every channel in m to deliver again
  task automatic wait_all(input logic [7:0] m);
    int n;
    n = 0;
    apb(1'b1, ADF_OFS_STATUS, 32'hff);
    do begin
      @(posedge pclk);
      n++;
    end while ((data_ready & m) !== m && n < 9000);
    if (n >= 9000) mismatches++;
    if (n >= 9000) complete_run();
    @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(1'b0, ADF_OFS_CTRL, 32'h0);
    chk(q, 32'h3);
    apb(1'b0, ADF_OFS_THR_LOW, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, ADF_OFS_STATUS, 32'h0);
    chk(q[15:8], 8'hff);
    apb(1'b1, 8'h0c, 32'h1);
    chk(e, 1'b1);
  endtask
  // Window length doubles per ratio code, the sinc1 stage above 1024
  task automatic t_rates;
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, ADF_OFS_CTRL, 32'(c));
      wait_all(8'h01);
      wait_all(8'h01);
      t0 = rise_t[0];
      wait_all(8'h01);
      chk(near(rise_t[0] - t0, 256 << c, 8), 1'b1);
    end
    apb(1'b0, ADF_OFS_STATUS, 32'h0);
    chk(q[15:8], 8'h00);
  endtask
  // Ratio 128: offsets of 100 and -100 must land on 63 and -64
  task automatic t_phase;
    logic [9:0] ph[ADF_NCH] = '{10'h0, 10'h64, 10'h3f, 10'h39c, 10'h3c0, 10'h14, 10'h28, 10'h3ec};
    apb(1'b1, ADF_OFS_CTRL, 32'h0);
    for (int c = 0; c < ADF_NCH; c++) apb(1'b1, pg(ADF_PAGE_CFG, c), {22'h0, ph[c]});
    apb(1'b0, pg(ADF_PAGE_CFG, 3), 32'h0);
    chk(q, 32'h39c);
    wait_all(8'hff);
    wait_all(8'hff);
    chk(near(cd(rise_t[1], rise_t[2], 0), 0, 6), 1'b1);
    chk(near(cd(rise_t[3], rise_t[4], 0), 0, 6), 1'b1);
    chk(near(cd(rise_t[2], rise_t[0], 126), 0, 6), 1'b1);
    chk(near(cd(rise_t[4], rise_t[0], 128), 0, 6), 1'b1);
  endtask
  task automatic t_mux;
    int ev[5] = '{8388607, 0, 1118481, -1118481, -8388608};
    int tv[5] = '{0, 4096, 65536, 65536, 0};
    for (int c = 0; c < 5; c++) apb(1'b1, pg(ADF_PAGE_CFG, c), 32'((c % 4) << 12));
    repeat (4) wait_all(8'h1f);
    for (int c = 0; c < 5; c++) begin
      apb(1'b0, pg(ADF_PAGE_DATA, c), 32'h0);
      chk(near(32'($signed(q[23:0])), ev[c], tv[c]), 1'b1);
    end
  endtask
  task automatic t_hp;
    apb(1'b1, pg(ADF_PAGE_CFG, 1), 32'h10000);
    apb(1'b1, ADF_OFS_THR_LOW, 32'h1);
    repeat (20) wait_all(8'h03);
    apb(1'b0, pg(ADF_PAGE_DATA, 0), 32'h0);
    chk(near(32'($signed(q[23:0])), 0, 65536), 1'b1);
    apb(1'b0, pg(ADF_PAGE_DATA, 1), 32'h0);
    chk(q, 32'h7fffff);
    apb(1'b1, ADF_OFS_THR_LOW, 32'h0);
    repeat (2) wait_all(8'h01);
    apb(1'b0, pg(ADF_PAGE_DATA, 0), 32'h0);
    chk(q, 32'h7fffff);
    apb(1'b1, ADF_OFS_THR_LOW, 32'h4);
    repeat (40) wait_all(8'h01);
    apb(1'b0, pg(ADF_PAGE_DATA, 0), 32'h0);
    chk(near(32'($signed(q[23:0])), 2359296, 471859), 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_rates();
    t_phase();
    t_mux();
    t_hp();
    complete_run();
  end
endmodule
`default_nettype wire
